// file: rtl/qsc_pkg.sv
// Purpose: Shared constants and types for the query statistics counter block.
// Assumes: One pipeline clock; all event sources sit on that clock.
// Notes:   Counter slot 0 is the occlusion counter, slots 1 to 11 the statistics.
package qsc_pkg;

	// ---------------------------------------------------------------
	// Sizes
	// ---------------------------------------------------------------
	localparam int NCNT = 12;        // Occlusion plus eleven statistics.
	localparam int NSTAT = 11;
	localparam int CW = 64;          // Counter width.
	localparam int AMW = 8;          // Increment width per event.
	localparam int QIW = 3;          // Query index width.
	localparam int NQ = 8;           // Queries tracked for availability.
	localparam int CSW = 4;          // Counter select width.

	// ---------------------------------------------------------------
	// Register byte offsets
	// ---------------------------------------------------------------
	localparam logic [7:0] OFF_CTRL   = 8'h00;
	localparam logic [7:0] OFF_PMASK  = 8'h04;
	localparam logic [7:0] OFF_IMASK  = 8'h08;
	localparam logic [7:0] OFF_STATUS = 8'h0c;
	localparam logic [7:0] OFF_RSEL   = 8'h10;
	localparam logic [7:0] OFF_RES_LO = 8'h14;
	localparam logic [7:0] OFF_RES_HI = 8'h18;
	localparam logic [7:0] OFF_AVAIL  = 8'h1c;

	// ---------------------------------------------------------------
	// Control, status and result-select field positions and reset values
	// ---------------------------------------------------------------
	localparam int CTRL_EXACT = 0;   // exact_count_control.
	localparam int CTRL_DROP  = 1;   // raster_drop_control.
	localparam int CTRL_WIDE  = 2;   // wide_result_option.
	localparam int CTRL_AVREP = 3;   // Availability reporting.
	localparam int CTRL_INHER = 4;   // Use the inherited mask.
	localparam int CTRL_GFX   = 5;   // Queue performs graphics work.
	localparam int CTRL_CMP   = 6;   // Queue performs compute work.
	localparam int CTRL_W     = 7;
	localparam int STS_REFUSED = 2;
	localparam int STS_CAP     = 3;
	localparam int STS_AVAIL   = 8;
	localparam int RSEL_Q      = 4;
	localparam logic [CTRL_W-1:0] CTRL_RST = 7'h00;
	localparam logic [NSTAT-1:0]  MASK_RST = 11'h000;

	// ---------------------------------------------------------------
	// Statistics slots within the stat event vectors
	// ---------------------------------------------------------------
	localparam int SI_IA_VERT  = 0;
	localparam int SI_IA_PRIM  = 1;
	localparam int SI_VS_INV   = 2;
	localparam int SI_GS_INV   = 3;
	localparam int SI_GS_PRIM  = 4;
	localparam int SI_CLIP_IN  = 5;
	localparam int SI_CLIP_OUT = 6;
	localparam int SI_FS_INV   = 7;
	localparam int SI_TCS_PAT  = 8;
	localparam int SI_TES_INV  = 9;
	localparam int SI_CS_INV   = 10;

	typedef enum logic [1:0] {
		QSC_IDLE = 2'b00,
		QSC_OCC  = 2'b01,
		QSC_STAT = 2'b10
	} qsc_state_t;

	typedef enum logic {
		QSC_KIND_OCC  = 1'b0,
		QSC_KIND_STAT = 1'b1
	} qsc_kind_t;

endpackage

// file: rtl/qsc_cnt_if.sv
// Purpose: Carrier between the query controller and the counter bank.
// Assumes: Both ends run on sys_clk.
// Notes:   clr wins over inc in the bank.
`timescale 1ns/10ps
interface qsc_cnt_if;
	import qsc_pkg::*;
	logic                          clr;
	logic [NCNT-1:0]               inc;
	logic [NCNT-1:0][AMW-1:0]      amt;
	logic [NCNT-1:0][CW-1:0]       val;
	modport ctl  (output clr, output inc, output amt, input val);
	modport bank (input clr, input inc, input amt, output val);
endinterface

// file: rtl/qsc_counter_bank.sv
// Purpose: Twelve 64-bit accumulating counters with a common clear.
// Assumes: Increments come from logic on the same clock.
// Notes:   A clear in the same cycle as an increment drops the increment.
`timescale 1ns/10ps
module qsc_counter_bank
	import qsc_pkg::*;
(
	input  wire logic sys_clk,
	input  wire logic rstn,
	qsc_cnt_if.bank   cb
);
	import qsc_pkg::*;

	typedef struct packed {
		logic [NCNT-1:0][CW-1:0] cnt;
	} qsc_bank_state_t;

	qsc_bank_state_t         s_q;
	qsc_bank_state_t         s_d;
	logic [NCNT-1:0][CW-1:0] nxt;

	// ---------------------------------------------------------------
	// Per-counter next value
	// ---------------------------------------------------------------
	// Each counter adds its zero-extended amount; wrap at 64 bits is harmless in practice.
	for (genvar i = 0; i < NCNT; i++) begin : g_cnt
		assign nxt[i] = cb.clr ? '0 :
			cb.inc[i] ? s_q.cnt[i] + {{(CW-AMW){1'b0}}, cb.amt[i]} : s_q.cnt[i];
	end

	// Collect the next state.
	always_comb begin
		s_d = s_q;
		s_d.cnt = nxt;
	end

	// State register.
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign cb.val = s_q.cnt;

endmodule

// file: rtl/qsc_top.sv
// Purpose: Occlusion and pipeline statistics query counters with an APB register file.
// Assumes: Command strobes and stage events are one-cycle pulses on sys_clk.
// Notes:   One query is active at a time; results belong to the last query ended.
`timescale 1ns/10ps

// Overview of operation
// [RULE_01] Starting an occlusion query clears the passing-sample counter first.
// [RULE_02] Without exact counting, any non-zero value for non-zero samples; zero stays zero.
// [RULE_03] Occlusion queries only start on a graphics queue.
// [RULE_04] Ending an occlusion query marks its result available.
// [RULE_05] Statistics queries need the capability bit and a graphics or compute queue.
// [RULE_06] Starting a statistics query clears every statistics counter.
// [RULE_07] Each statistics counter counts only when its mask bit is set.
// [RULE_08] A counter enabled without matching work may hold any value.
// [RULE_09] The issuer enables at least one relevant statistics counter.
// [RULE_10] Input-assembly vertex counter counts every vertex, incomplete ones allowed.
// [RULE_11] Input-assembly primitive counter ignores primitive restart.
// [RULE_12] Vertex-shader counter adds one per invocation.
// [RULE_13] Geometry-shader counter adds one per invocation or instance.
// [RULE_14] Geometry output primitive counter ignores restart instructions.
// [RULE_15] Clipping-input counter adds one per primitive reaching clipping.
// [RULE_16] Clipping-output adds at least one when a vertex lies inside.
// [RULE_17] Fragment-shader counter adds per invocation.
// [RULE_18] Tessellation-control counter adds exactly one per patch.
// [RULE_19] Tessellation-evaluation counter adds per invocation.
// [RULE_20] Compute-shader counter adds per invocation as reported.
// [RULE_21] With raster drop on, clipping counters may stay unchanged.
// [RULE_22] Ending a statistics query marks its result available.
// [RULE_23] Results read as low 32 bits; unavailable results return nothing.
// [RULE_24] Availability word is non-zero when available, zero otherwise.
// [RULE_25] Counting happens only between begin and end strobes of the active query.
// [RULE_26] Counters are 64 bits; narrow readout gives the low half.
module qsc_top
	import qsc_pkg::*;
(
	input  wire logic                            sys_clk,
	input  wire logic                            rstn,
	input  wire logic [7:0]                      paddr,
	input  wire logic                            psel,
	input  wire logic                            penable,
	input  wire logic                            pwrite,
	input  wire logic [31:0]                     pwdata,
	output logic      [31:0]                     prdata,
	output logic                                 pready,
	output logic                                 pslverr,
	input  wire logic                            query_begin_command,
	input  wire logic                            query_end_command,
	input  wire logic [qsc_pkg::QIW-1:0]         query_index,
	input  wire qsc_pkg::qsc_kind_t              query_kind,
	input  wire logic                            stat_query_capability,
	input  wire logic                            smp_valid,
	input  wire logic [qsc_pkg::AMW-1:0]         smp_count,
	input  wire logic [qsc_pkg::NSTAT-1:0]       stat_event_valid,
	input  wire logic [qsc_pkg::NSTAT-1:0][qsc_pkg::AMW-1:0] stat_event_count,
	input  wire logic                            ia_prim_restart,
	input  wire logic                            geom_primitive_restart_instr,
	input  wire logic                            geom_stream_restart_instr,
	input  wire logic                            clip_vtx_inside,
	output logic                                 query_active,
	output logic      [qsc_pkg::NQ-1:0]          query_avail
);
	import qsc_pkg::*;

	// ---------------------------------------------------------------
	// State
	// ---------------------------------------------------------------
	typedef struct packed {
		qsc_state_t          st;
		logic [QIW-1:0]      idx;
		logic [NQ-1:0]       avail;
		logic [QIW-1:0]      last_idx;
		qsc_kind_t           last_kind;
		logic [CTRL_W-1:0]   ctrl;
		logic [NSTAT-1:0]    pool_mask;
		logic [NSTAT-1:0]    inh_mask;
		logic                refused;
		logic [CSW-1:0]      rsel_cnt;
		logic [QIW-1:0]      rsel_q;
		logic [31:0]         rdata;
		logic                slverr;
	} qsc_top_state_t;

	qsc_top_state_t          s_q;
	qsc_top_state_t          s_d;
	qsc_cnt_if               cb ();

	logic [NSTAT-1:0]        stat_mask;
	logic [NSTAT-1:0]        stat_veto;
	logic [NSTAT-1:0]        stat_go;
	logic [NSTAT-1:0][AMW-1:0] stat_amt;
	logic [AMW-1:0]          occ_amt;
	logic                    occ_go;
	logic [CW-1:0]           res_val;
	logic                    res_ok;
	logic                    sel_ok;
	logic                    gfx_q;
	logic                    cmp_q;
	logic                    setup;
	logic                    access;

	// ---------------------------------------------------------------
	// Counter bank
	// ---------------------------------------------------------------
	qsc_counter_bank u_bank (
		.sys_clk (sys_clk),
		.rstn    (rstn),
		.cb      (cb.bank)
	);

	assign gfx_q = s_q.ctrl[CTRL_GFX];
	assign cmp_q = s_q.ctrl[CTRL_CMP];

	// Secondary streams count with the inherited mask instead of the pool mask.
	assign stat_mask = s_q.ctrl[CTRL_INHER] ? s_q.inh_mask : s_q.pool_mask; // RULE_07

	// ---------------------------------------------------------------
	// Event qualification
	// ---------------------------------------------------------------
	// Events qualified away here never reach the counters; the rest count per event.
	always_comb begin
		stat_veto = '0;
		stat_veto[SI_IA_PRIM] = ia_prim_restart; // RULE_11
		stat_veto[SI_GS_PRIM] = geom_primitive_restart_instr | geom_stream_restart_instr; // RULE_14
		// Dropped primitives never reach clipping, so both clipping counts hold.
		stat_veto[SI_CLIP_IN] = s_q.ctrl[CTRL_DROP]; // RULE_21
		stat_veto[SI_CLIP_OUT] = s_q.ctrl[CTRL_DROP]; // RULE_21
	end

	// Per-statistic gating and amounts; counts arrive only while the query is active.
	for (genvar i = 0; i < NSTAT; i++) begin : g_stat
		assign stat_go[i] = (s_q.st == QSC_STAT) & stat_event_valid[i]
			& stat_mask[i] & ~stat_veto[i]; // RULE_25
		if (i == SI_VS_INV || i == SI_CLIP_IN || i == SI_TCS_PAT) begin : g_one
			// These stages add exactly one per reported event.
			assign stat_amt[i] = {{(AMW-1){1'b0}}, 1'b1}; // RULE_12 RULE_15 RULE_18
		end else if (i == SI_CLIP_OUT) begin : g_clip
			// An inside vertex guarantees at least one output primitive is counted.
			assign stat_amt[i] = (clip_vtx_inside && stat_event_count[i] == '0) ?
				{{(AMW-1){1'b0}}, 1'b1} : stat_event_count[i]; // RULE_16
		end else begin : g_cnt
			// Counts of vertices, primitives, instances and invocations as the stage reports them.
			assign stat_amt[i] = stat_event_count[i]; // RULE_10 RULE_13 RULE_17 RULE_19 RULE_20
		end
	end

	// Coarse mode only ever raises the count from zero to one, which is cheaper to hold.
	assign occ_go = (s_q.st == QSC_OCC) & smp_valid; // RULE_25
	assign occ_amt = s_q.ctrl[CTRL_EXACT] ? smp_count :
		((cb.val[0] == '0 && smp_count != '0) ? {{(AMW-1){1'b0}}, 1'b1} : '0); // RULE_02

	assign cb.inc = {stat_go, occ_go};
	assign cb.amt = {stat_amt, occ_amt};

	// ---------------------------------------------------------------
	// Result selection
	// ---------------------------------------------------------------
	// A result exists only for the last query ended, and only in its own counter slots.
	always_comb begin
		sel_ok = 1'b0;
		if (s_q.last_kind == QSC_KIND_OCC) begin
			sel_ok = (s_q.rsel_cnt == '0);
		end else begin
			sel_ok = (s_q.rsel_cnt != '0) && (s_q.rsel_cnt < CSW'(NCNT));
		end
		res_ok = sel_ok && s_q.avail[s_q.rsel_q] && (s_q.rsel_q == s_q.last_idx); // RULE_23
		res_val = (s_q.rsel_cnt < CSW'(NCNT)) ? cb.val[s_q.rsel_cnt] : '0;
	end

	assign setup = psel & ~penable;
	assign access = psel & penable;

	// ---------------------------------------------------------------
	// Query sequencing and register file
	// ---------------------------------------------------------------
	// Enabled counters with no matching work on this queue are left to count what arrives.
	always_comb begin
		s_d = s_q;
		cb.clr = 1'b0; // RULE_08
		// Register writes take effect at the end of the access phase.
		if (access && pwrite) begin
			case (paddr)
				OFF_CTRL: begin
					s_d.ctrl = pwdata[CTRL_W-1:0];
				end
				OFF_PMASK: begin
					s_d.pool_mask = pwdata[NSTAT-1:0];
				end
				OFF_IMASK: begin
					s_d.inh_mask = pwdata[NSTAT-1:0];
				end
				OFF_STATUS: begin
					if (pwdata[STS_REFUSED]) begin
						s_d.refused = 1'b0;
					end
				end
				OFF_RSEL: begin
					s_d.rsel_cnt = pwdata[CSW-1:0];
					s_d.rsel_q = pwdata[RSEL_Q+QIW-1:RSEL_Q];
				end
				default: begin
				end
			endcase
		end
		// Ending the matching active query publishes its result.
		if (query_end_command) begin
			if (s_q.st != QSC_IDLE && query_index == s_q.idx) begin
				s_d.st = QSC_IDLE;
				s_d.avail[s_q.idx] = 1'b1; // RULE_04 RULE_22
				s_d.last_idx = s_q.idx;
				s_d.last_kind = (s_q.st == QSC_OCC) ? QSC_KIND_OCC : QSC_KIND_STAT;
			end else begin
				s_d.refused = 1'b1;
			end
		end
		// A begin while busy, or on an unsupported queue, is refused and flagged.
		if (query_begin_command) begin
			if (s_q.st != QSC_IDLE) begin
				s_d.refused = 1'b1;
			end else if (query_kind == QSC_KIND_OCC) begin
				if (gfx_q) begin // RULE_03
					s_d.st = QSC_OCC;
					s_d.idx = query_index;
					s_d.avail[query_index] = 1'b0;
					cb.clr = 1'b1; // RULE_01
				end else begin
					s_d.refused = 1'b1;
				end
			end else if (stat_query_capability && (gfx_q || cmp_q)) begin // RULE_05
				s_d.st = QSC_STAT;
				s_d.idx = query_index;
				s_d.avail[query_index] = 1'b0;
				cb.clr = 1'b1; // RULE_06
			end else begin
				s_d.refused = 1'b1;
			end
		end
		// Read data and error are prepared during setup for a zero-wait access.
		if (setup) begin
			s_d.rdata = '0;
			s_d.slverr = 1'b0;
			case (paddr)
				OFF_CTRL: begin
					s_d.rdata[CTRL_W-1:0] = s_q.ctrl;
				end
				OFF_PMASK: begin
					s_d.rdata[NSTAT-1:0] = s_q.pool_mask;
				end
				OFF_IMASK: begin
					s_d.rdata[NSTAT-1:0] = s_q.inh_mask;
				end
				OFF_STATUS: begin
					s_d.rdata[1:0] = s_q.st;
					s_d.rdata[STS_REFUSED] = s_q.refused;
					s_d.rdata[STS_CAP] = stat_query_capability;
					s_d.rdata[STS_AVAIL+NQ-1:STS_AVAIL] = s_q.avail;
				end
				OFF_RSEL: begin
					s_d.rdata[CSW-1:0] = s_q.rsel_cnt;
					s_d.rdata[RSEL_Q+QIW-1:RSEL_Q] = s_q.rsel_q;
				end
				OFF_RES_LO: begin
					// Unavailable results return no data and an error.
					s_d.rdata = res_ok ? res_val[31:0] : '0; // RULE_23 RULE_26
					s_d.slverr = ~res_ok & ~pwrite;
				end
				OFF_RES_HI: begin
					// Upper half only with the wide option; narrow results stop at 32 bits.
					s_d.rdata = (res_ok && s_q.ctrl[CTRL_WIDE]) ? res_val[CW-1:32] : '0; // RULE_26
					s_d.slverr = ~res_ok & ~pwrite;
				end
				OFF_AVAIL: begin
					s_d.rdata[0] = s_q.ctrl[CTRL_AVREP] & s_q.avail[s_q.rsel_q]; // RULE_24
				end
				default: begin
					s_d.slverr = 1'b1;
				end
			endcase
		end
	end

	// State register.
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			s_q <= '0;
			s_q.st <= QSC_IDLE;
			s_q.ctrl <= CTRL_RST;
			s_q.pool_mask <= MASK_RST;
			s_q.inh_mask <= MASK_RST;
		end else begin
			s_q <= s_d;
		end
	end

	// ---------------------------------------------------------------
	// Outputs
	// ---------------------------------------------------------------
	// The slave never inserts wait states.
	assign pready = 1'b1;
	assign prdata = s_q.rdata;
	assign pslverr = s_q.slverr;
	assign query_active = (s_q.st != QSC_IDLE);
	assign query_avail = s_q.avail;

endmodule

// file: tb/qsc_top_chk.sv
// Purpose: Concurrent checks on the query counter block ports.
// Assumes: One clock, asynchronous active-low reset.
// Notes:   Checks key on query_active; acceptance hangs on control.
`timescale 1ns/10ps
module qsc_top_chk
	import qsc_pkg::*;
(
	input wire logic                    sys_clk,
	input wire logic                    rstn,
	input wire logic [7:0]              paddr,
	input wire logic                    psel,
	input wire logic                    penable,
	input wire logic                    pwrite,
	input wire logic [31:0]             prdata,
	input wire logic                    pslverr,
	input wire logic                    query_begin_command,
	input wire logic                    query_end_command,
	input wire logic [qsc_pkg::QIW-1:0] query_index,
	input wire logic                    query_active,
	input wire logic [qsc_pkg::NQ-1:0]  query_avail
);
	// ---------------------------------------------------------------
	// Index of the running query
	// ---------------------------------------------------------------
	logic [QIW-1:0] run_idx_q;

	// A refused begin runs nothing, so its index goes unused.
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			run_idx_q <= '0;
		end else if (query_begin_command && !query_active) begin
			run_idx_q <= query_index;
		end
	end

	default clocking @(posedge sys_clk);
	endclocking
	default disable iff (!rstn);

	a_start_from_begin: assert property ($rose(query_active) |->
		$past(query_begin_command) && !query_avail[run_idx_q]) else $error("bad query start");
	a_stop_from_end: assert property ($fell(query_active) |->
		$past(query_end_command) && $past(query_index) == run_idx_q) else $error("bad stop");
	a_end_completes: assert property (query_active && query_end_command &&
		query_index == run_idx_q |=> !query_active && query_avail[run_idx_q])
		else $error("end did not finish");
	a_begin_refused: assert property (query_active && query_begin_command &&
		!query_end_command |=> query_active) else $error("begin broke the query");
	a_avail_set_cause: assert property ((query_avail & ~$past(query_avail)) != '0 |->
		$past(query_end_command)) else $error("avail rose without end");
	a_avail_hold: assert property ((~query_avail & $past(query_avail)) != '0 |->
		$past(query_begin_command)) else $error("avail dropped without begin");
	a_result_unavail: assert property (psel && !penable && !pwrite &&
		paddr == OFF_RES_LO && query_avail == '0 |=> pslverr && prdata == 32'h0)
		else $error("unavailable result read");
	a_unmapped_err: assert property (psel && !penable &&
		(paddr > OFF_AVAIL || paddr[1:0] != 2'b00) |=> pslverr) else $error("no error");
	a_read_stands: assert property (!(psel && !penable) |=>
		$stable(prdata) && $stable(pslverr)) else $error("read data moved");

	c_query_run: cover property ($rose(query_active));
	c_query_end: cover property ($fell(query_active));
	c_error_read: cover property (psel && penable && pslverr);
endmodule

bind qsc_top qsc_top_chk u_chk (
	.sys_clk, .rstn, .paddr, .psel, .penable, .pwrite, .prdata, .pslverr,
	.query_begin_command, .query_end_command, .query_index, .query_active, .query_avail
);

// file: tb/qsc_pipe_model.sv
// Purpose: Model of the command processor and pipeline stages.
// Assumes: Strobes are one-cycle pulses launched just after a rising edge.
// Notes:   Released lines show their inverse to expose stale use.
`timescale 1ns/10ps
module qsc_pipe_model
	import qsc_pkg::*;
(
	input  wire logic                                        sys_clk,
	output logic                                             query_begin_command,
	output logic                                             query_end_command,
	output logic [qsc_pkg::QIW-1:0]                          query_index,
	output qsc_pkg::qsc_kind_t                               query_kind,
	output logic                                             smp_valid,
	output logic [qsc_pkg::AMW-1:0]                          smp_count,
	output logic [qsc_pkg::NSTAT-1:0]                        stat_event_valid,
	output logic [qsc_pkg::NSTAT-1:0][qsc_pkg::AMW-1:0]      stat_event_count,
	output logic                                             ia_prim_restart,
	output logic                                             geom_primitive_restart_instr,
	output logic                                             geom_stream_restart_instr,
	output logic                                             clip_vtx_inside
);
	// ---------------------------------------------------------------
	// Drivers
	// ---------------------------------------------------------------
	logic [3:0] qual;

	// Qualifiers travel as one group.
	assign {ia_prim_restart, geom_primitive_restart_instr, geom_stream_restart_instr,
		clip_vtx_inside} = qual;

	// Quiet lines at time zero, so reset sees no event.
	initial begin
		{query_begin_command, query_end_command, query_index, smp_valid, smp_count} = '0;
		{stat_event_valid, stat_event_count, qual} = '0;
		query_kind = QSC_KIND_OCC;
	end

	// One command pulse; index and kind turn over afterwards.
	task automatic cmd(input logic b, input logic e, input logic [QIW-1:0] idx, input qsc_kind_t k);
		@(posedge sys_clk);
		query_begin_command <= b;
		query_end_command   <= e;
		query_index         <= idx;
		query_kind          <= k;
		@(posedge sys_clk);
		query_begin_command <= 1'b0;
		query_end_command   <= 1'b0;
		query_index         <= ~idx;
		query_kind          <= qsc_kind_t'(~k);
	endtask

	// One stage event; slot NSTAT stands for passing samples.
	task automatic ev(input int s, input logic [AMW-1:0] c, input logic [3:0] q);
		@(posedge sys_clk);
		if (s == NSTAT) begin
			smp_valid <= 1'b1;
			smp_count <= c;
		end else begin
			stat_event_valid[s] <= 1'b1;
			stat_event_count[s] <= c;
		end
		qual <= q;
		@(posedge sys_clk);
		smp_valid        <= 1'b0;
		stat_event_valid <= '0;
		smp_count        <= ~smp_count;
		stat_event_count <= ~stat_event_count;
		qual             <= ~q;
	endtask
endmodule

// file: tb/qsc_top_test.sv
// Purpose: Self-checking bench for the query counter block.
// Assumes: Inputs change just after rising edges.
// Notes:   Expected counts come from the amounts sent, not the block.
`timescale 1ns/10ps
module qsc_top_test;
	import qsc_pkg::*;
	logic                      sys_clk, rstn, psel, penable, pwrite, pready, pslverr, err;
	logic                      query_begin_command, query_end_command, stat_query_capability;
	logic                      smp_valid, ia_prim_restart, geom_primitive_restart_instr;
	logic                      geom_stream_restart_instr, clip_vtx_inside, query_active;
	logic [7:0]                paddr;
	logic [31:0]               pwdata, prdata, rd;
	logic [QIW-1:0]            query_index;
	qsc_kind_t                 query_kind;
	logic [AMW-1:0]            smp_count;
	logic [NSTAT-1:0]          stat_event_valid;
	logic [NSTAT-1:0][AMW-1:0] stat_event_count;
	logic [NQ-1:0]             query_avail;
	int                        n_mismatch, compares;

	qsc_top uut (
		.sys_clk, .rstn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
		.query_begin_command, .query_end_command, .query_index, .query_kind,
		.stat_query_capability, .smp_valid, .smp_count, .stat_event_valid, .stat_event_count,
		.ia_prim_restart, .geom_primitive_restart_instr, .geom_stream_restart_instr,
		.clip_vtx_inside, .query_active, .query_avail
	);
	qsc_pipe_model pipe (.*);

	// ---------------------------------------------------------------
	// Tasks
	// ---------------------------------------------------------------
	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		compares++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("BAD %0t seen %0h expected %0h", $time, seen, exp);
		end
	endtask

	// One APB transfer, held until pready is seen at an edge.
	task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
		@(posedge sys_clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		paddr   <= a;
		pwrite  <= w;
		pwdata  <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		@(posedge sys_clk);
		while (pready !== 1'b1) @(posedge sys_clk);
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rdchk(input logic [7:0] a, input logic [31:0] d, input logic e);
		apb(a, 1'b0, 32'h0);
		check(rd, d);
		check({err, pready}, {e, 1'b1});
	endtask

	// Expected statistic; pass 1 uses the inherited mask and raster drop.
	function automatic logic [31:0] expect_cnt(input int s, input int p);
		logic [NSTAT-1:0] m;
		m = (p == 1) ? 11'h7fb : 11'h7f7;
		if (!m[s] || (p == 1 && (s == SI_CLIP_IN || s == SI_CLIP_OUT))) begin
			return 32'h0;
		end
		if (s == SI_VS_INV || s == SI_CLIP_IN || s == SI_TCS_PAT) begin
			return 32'h1;
		end
		if (s == SI_CLIP_OUT) begin
			return 32'h9;
		end
		return 32'(s + 2);
	endfunction

	task automatic finish_test;
		$display("Comparisons %0d mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	initial begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end

	// A few hundred cycles suffice; 20000 means a hang.
	initial begin
		#80000;
		n_mismatch++;
		finish_test();
	end

	initial begin
		{psel, penable, pwrite, stat_query_capability, paddr, pwdata} = '0;
		n_mismatch = 0;
		compares = 0;
		rstn = 1'b0;
		repeat (4) @(posedge sys_clk);
		rstn <= 1'b1;
		rdchk(OFF_CTRL, 32'h0, 1'b0);
		rdchk(OFF_PMASK, 32'h0, 1'b0);
		rdchk(8'h20, 32'h0, 1'b1);
		rdchk(OFF_RES_LO, 32'h0, 1'b1);
		// Occlusion refused without graphics, statistics without capability.
		pipe.cmd(1'b1, 1'b0, 3'd0, QSC_KIND_OCC);
		pipe.ev(NSTAT, 8'd5, 4'h0);
		check(query_active, 1'b0);
		rdchk(OFF_STATUS, 32'h4, 1'b0);
		apb(OFF_STATUS, 1'b1, 32'h4);
		apb(OFF_CTRL, 1'b1, 32'h60);
		pipe.cmd(1'b1, 1'b0, 3'd0, QSC_KIND_STAT);
		rdchk(OFF_STATUS, 32'h4, 1'b0);
		apb(OFF_STATUS, 1'b1, 32'h4);
		// Occlusion, exact then coarse; samples outside the query must not count.
		for (int ex = 1; ex >= 0; ex--) begin
			apb(OFF_CTRL, 1'b1, 32'h20 | 32'(ex));
			pipe.ev(NSTAT, 8'd9, 4'h0);
			pipe.cmd(1'b1, 1'b0, 3'd1, QSC_KIND_OCC);
			pipe.ev(NSTAT, 8'd3, 4'h0);
			pipe.ev(NSTAT, 8'd4, 4'h0);
			pipe.cmd(1'b0, 1'b1, 3'd1, QSC_KIND_OCC);
			pipe.ev(NSTAT, 8'd9, 4'h0);
			check(query_avail[1], 1'b1);
			apb(OFF_RSEL, 1'b1, 32'h10);
			apb(OFF_RES_LO, 1'b0, 32'h0);
			check((ex == 1) ? rd : 32'(rd != 32'h0), (ex == 1) ? 32'd7 : 32'd1);
		end
		pipe.cmd(1'b1, 1'b0, 3'd1, QSC_KIND_OCC);
		pipe.cmd(1'b0, 1'b1, 3'd1, QSC_KIND_OCC);
		rdchk(OFF_RES_LO, 32'h0, 1'b0);
		// Statistics twice with the same traffic, so a missed clear doubles the counts.
		stat_query_capability <= 1'b1;
		apb(OFF_PMASK, 1'b1, 32'h7f7);
		apb(OFF_IMASK, 1'b1, 32'h7fb);
		for (int p = 0; p < 2; p++) begin
			apb(OFF_CTRL, 1'b1, (p == 1) ? 32'h76 : 32'h68);
			pipe.cmd(1'b1, 1'b0, 3'(2 + p), QSC_KIND_STAT);
			for (int s = 0; s < NSTAT; s++) begin
				pipe.ev(s, 8'(s + 2), 4'h0);
			end
			pipe.ev(SI_IA_PRIM, 8'd5, 4'h8);
			pipe.ev(SI_GS_PRIM, 8'd5, 4'h4);
			pipe.ev(SI_GS_PRIM, 8'd5, 4'h2);
			pipe.ev(SI_CLIP_OUT, 8'd0, 4'h1);
			pipe.cmd(1'b0, 1'b1, 3'(2 + p), QSC_KIND_STAT);
			@(negedge sys_clk);
			check(query_avail[2 + p], 1'b1);
			for (int s = 0; s < NSTAT; s++) begin
				apb(OFF_RSEL, 1'b1, 32'((2 + p) * 16 + s + 1));
				rdchk(OFF_RES_LO, expect_cnt(s, p), 1'b0);
				rdchk(OFF_RES_HI, 32'h0, 1'b0);
			end
			rdchk(OFF_AVAIL, (p == 1) ? 32'h0 : 32'h1, 1'b0);
		end
		// Refusals: stale read, busy begin, foreign end index.
		apb(OFF_RSEL, 1'b1, 32'h10);
		rdchk(OFF_RES_LO, 32'h0, 1'b1);
		pipe.cmd(1'b1, 1'b0, 3'd4, QSC_KIND_STAT);
		pipe.cmd(1'b1, 1'b0, 3'd5, QSC_KIND_STAT);
		pipe.cmd(1'b0, 1'b1, 3'd6, QSC_KIND_STAT);
		@(negedge sys_clk);
		check(query_active, 1'b1);
		rdchk(OFF_STATUS, 32'h0e0e, 1'b0);
		pipe.cmd(1'b1, 1'b1, 3'd4, QSC_KIND_STAT);
		@(negedge sys_clk);
		check({query_active, query_avail[4]}, 2'b01);
		finish_test();
	end
endmodule
